// ---- verilog/dc_drive_pkg.sv ----
// Purpose: Constants shared by the direct-drive coil controller
// Assumes: 20 MHz clock, 32-bit register write port
// Notes: Register index is the printed offset
package dc_drive_pkg;
    localparam logic [7:0] COIL_PWM_SETPOINT_ADDR = 8'h2d;
    localparam logic [31:0] COIL_PWM_SETPOINT_RESET = 32'h0000_0000;
    localparam int COIL_A_LSB = 0;
    localparam int COIL_B_LSB = 16;
    localparam int FIELD_W = 9;
    localparam logic [8:0] FULL_SCALE = 9'h0ff;
    localparam logic [1:0] COAST_COAST_SELECT = 2'h1;
    localparam logic [7:0] PWM_PERIOD = 8'hfe;
    // Hold delay unit in clock cycles per decay step
    localparam int DECAY_STEP_CYCLES = 262144;
    // Power-down delay unit in clock cycles
    localparam int IDLE_UNIT_CYCLES = 262144;
    localparam logic [4:0] CURRENT_RESET = 5'h00;
    typedef enum logic [1:0] {
        MODE_VOLT,
        MODE_VOLT_LIMIT,
        MODE_HYST
    } chop_mode_t;
endpackage

// ---- verilog/coil_bridge.sv ----
// Purpose: One coil bridge: PWM or hysteresis drive for a signed setpoint
// Assumes: Setpoint is already sign extended to ten bits
// Notes: Outputs are registered
`timescale 1ns/10ps
module coil_bridge (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Control
    input wire logic enable,
    input wire logic hyst_mode,
    input wire logic [7:0] pwm_cnt,
    input wire logic [9:0] setpoint,
    input wire logic [7:0] duty_scale,
    input wire logic [8:0] limit,
    input wire logic [8:0] sensed,
    // Bridge
    output logic hi_a,
    output logic hi_b,
    output logic over_limit
);
    logic [8:0] mag;
    logic [15:0] prod;
    logic [7:0] duty;
    logic on, hi_a_next, hi_b_next, over_next;

    always_comb begin
        mag = setpoint[9] ? 9'(-setpoint) : setpoint[8:0];
        if (mag > 9'h0ff) begin
            mag = 9'h0ff;
        end
        prod = mag[7:0] * duty_scale;
        duty = prod[15:8];
        over_next = sensed >= limit;
        // Hysteresis drives until current reaches limit
        on = hyst_mode ? !over_next : (pwm_cnt < duty);
        hi_a_next = enable && on && !setpoint[9];
        hi_b_next = enable && on && setpoint[9];
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            hi_a <= 1'b0;
            hi_b <= 1'b0;
            over_limit <= 1'b0;
        end else begin
            hi_a <= hi_a_next;
            hi_b <= hi_b_next;
            over_limit <= over_next && enable;
        end
    end
endmodule // coil_bridge

// ---- verilog/dc_motor_direct_drive.sv ----
// Purpose: Direct drive of two DC motors or solenoids from one setpoint
// Assumes: Register writes arrive as a one-cycle strobe with index and data
// Notes: Sense values are 9-bit unsigned magnitudes; current settings are 5-bit
`timescale 1ns/10ps
module dc_motor_direct_drive (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Register write/read port
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    // Configuration
    input wire logic DIRECT_MODE,
    input wire logic VOLT_MODE,
    input wire logic AUTOSCALE,
    input wire logic [3:0] CHOPPER_OFF_TIME,
    input wire logic [4:0] STANDSTILL_CURRENT,
    input wire logic [4:0] MOVING_CURRENT,
    input wire logic [3:0] CURRENT_DECAY_STEPS,
    input wire logic [7:0] IDLE_REDUCE_DELAY,
    input wire logic [1:0] COAST_SELECT,
    // Step input and motion controller coil drive
    input wire logic STEP,
    input wire logic [8:0] MOTION_COIL_A,
    input wire logic [8:0] MOTION_COIL_B,
    // Sensed coil currents
    input wire logic [8:0] SENSE_A,
    input wire logic [8:0] SENSE_B,
    // Bridge drive
    output logic COIL_A_POS,
    output logic COIL_A_NEG,
    output logic COIL_B_POS,
    output logic COIL_B_NEG,
    output logic BRIDGE_EN,
    output logic COASTING,
    output logic [4:0] ACTIVE_CURRENT
);
    import dc_drive_pkg::*;

    function automatic logic [9:0] sext9(input logic [8:0] v);
        return {v[8], v};
    endfunction

    function automatic logic [8:0] absval(input logic [9:0] v);
        logic [9:0] n;
        n = v[9] ? -v : v;
        return (n > 10'(FULL_SCALE)) ? FULL_SCALE : n[8:0];
    endfunction

    // ----------------------------------------------------------------
    // Register and state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {S_HOLD, S_RUN, S_DECAY} cur_state_t;

    logic [31:0] setpoint_reg, setpoint_next;
    cur_state_t state_reg, state_next;
    logic [4:0] cur_reg, cur_next;
    logic [17:0] tmr_reg, tmr_next;
    logic [7:0] units_reg, units_next;
    logic [7:0] pwm_reg, pwm_next;
    logic [7:0] reduce_reg, reduce_next;
    logic step_q_reg;
    logic [31:0] rdata_next;
    logic en_next, coast_next;

    logic [9:0] sp_a, sp_b;
    logic [8:0] mag_a, mag_b, mag_max, lim_a, lim_b, hold_lim;
    logic [8:0] sense_a_use, sense_b_use;
    logic [13:0] hold_prod;
    logic [17:0] la_prod, lb_prod;
    logic step_edge, a_is_max, hyst, over_a;
    logic [7:0] scale_a, scale_b;

    // ----------------------------------------------------------------
    // Setpoint register and current scaling
    // ----------------------------------------------------------------
    always_comb begin
        setpoint_next = setpoint_reg;
        if (REG_WR && REG_ADDR == COIL_PWM_SETPOINT_ADDR) begin
            setpoint_next = REG_WDATA;
        end
        rdata_next = (REG_ADDR == COIL_PWM_SETPOINT_ADDR) ?
            setpoint_reg : 32'h0000_0000;
        step_edge = STEP && !step_q_reg;
        state_next = state_reg;
        cur_next = cur_reg;
        tmr_next = tmr_reg;
        units_next = units_reg;
        if (step_edge) begin
            // Both coils share one current scale
            state_next = S_RUN;
            cur_next = MOVING_CURRENT;
            tmr_next = '0;
            units_next = '0;
        end else begin
            unique case (state_reg)
                S_HOLD: cur_next = STANDSTILL_CURRENT;
                S_RUN: begin
                    tmr_next = tmr_reg + 18'h1;
                    if (tmr_reg == 18'(IDLE_UNIT_CYCLES - 1)) begin
                        tmr_next = '0;
                        units_next = units_reg + 8'h1;
                        if (units_reg >= IDLE_REDUCE_DELAY) begin
                            state_next = S_DECAY;
                            units_next = '0;
                        end
                    end
                end
                S_DECAY: begin
                    tmr_next = tmr_reg + 18'h1;
                    if (tmr_reg == 18'(DECAY_STEP_CYCLES - 1)) begin
                        tmr_next = '0;
                        units_next = units_reg + 8'h1;
                        if (units_reg[3:0] >= CURRENT_DECAY_STEPS) begin
                            units_next = '0;
                            if (cur_reg > STANDSTILL_CURRENT) begin
                                cur_next = cur_reg - 5'h1;
                            end else begin
                                cur_next = STANDSTILL_CURRENT;
                                state_next = S_HOLD;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Coil drive computation
    // ----------------------------------------------------------------
    always_comb begin
        // Direct drive bypasses the motion coil values
        sp_a = DIRECT_MODE ? sext9(setpoint_reg[COIL_A_LSB +: FIELD_W])
                           : sext9(MOTION_COIL_A);
        sp_b = DIRECT_MODE ? sext9(setpoint_reg[COIL_B_LSB +: FIELD_W])
                           : sext9(MOTION_COIL_B);
        mag_a = absval(sp_a);
        mag_b = absval(sp_b);
        a_is_max = mag_a >= mag_b;
        mag_max = a_is_max ? mag_a : mag_b;
        hyst = !VOLT_MODE;
        // Current limit from active current, 31 gives full scale
        hold_prod = 14'(cur_reg) * 14'h0108;
        hold_lim = (hold_prod[13:5] > FULL_SCALE) ? FULL_SCALE
                                                  : hold_prod[13:5];
        la_prod = 18'(hold_lim) * 18'(mag_a);
        lb_prod = 18'(hold_lim) * 18'(mag_b);
        if (hyst) begin
            lim_a = la_prod[16:8];
            lim_b = lb_prod[16:8];
        end else begin
            lim_a = a_is_max ? 9'(la_prod[17:8]) : 9'(lb_prod[17:8]);
            lim_b = lim_a;
        end
        // Voltage mode: sense only the larger motor, only with autoscale
        sense_a_use = (!hyst && !AUTOSCALE) ? 9'h000
                    : (!hyst ? (a_is_max ? SENSE_A : SENSE_B)
                             : SENSE_A);
        sense_b_use = hyst ? SENSE_B : 9'h000;
        pwm_next = (pwm_reg >= PWM_PERIOD) ? 8'h00 : pwm_reg + 8'h1;
        reduce_next = reduce_reg;
        if (!hyst && AUTOSCALE && pwm_reg == 8'h00) begin
            if (over_a && reduce_reg != 8'h00) begin
                reduce_next = reduce_reg - 8'h1;
            end else if (!over_a && reduce_reg != 8'hff) begin
                reduce_next = reduce_reg + 8'h1;
            end
        end else if (hyst || !AUTOSCALE) begin
            reduce_next = 8'hff;
        end
        // Shared reduction scales both PWMs
        scale_a = reduce_reg;
        scale_b = reduce_reg;
        en_next = CHOPPER_OFF_TIME != 4'h0;
        coast_next = STANDSTILL_CURRENT == 5'h00 &&
                     COAST_SELECT == COAST_COAST_SELECT;
        if (coast_next) begin
            en_next = 1'b0;
        end
    end

    coil_bridge bridge_a (
        .CLK(CLK),
        .RESETN(RESETN),
        .enable(en_next),
        .hyst_mode(hyst),
        .pwm_cnt(pwm_reg),
        .setpoint(sp_a),
        .duty_scale(scale_a),
        .limit(lim_a),
        .sensed(sense_a_use),
        .hi_a(COIL_A_POS),
        .hi_b(COIL_A_NEG),
        .over_limit(over_a)
    );

    coil_bridge bridge_b (
        .CLK(CLK),
        .RESETN(RESETN),
        .enable(en_next),
        .hyst_mode(hyst),
        .pwm_cnt(pwm_reg),
        .setpoint(sp_b),
        .duty_scale(scale_b),
        .limit(lim_b),
        .sensed(sense_b_use),
        .hi_a(COIL_B_POS),
        .hi_b(COIL_B_NEG),
        .over_limit()
    );

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            setpoint_reg <= COIL_PWM_SETPOINT_RESET;
            state_reg <= S_HOLD;
            cur_reg <= CURRENT_RESET;
            tmr_reg <= '0;
            units_reg <= '0;
            step_q_reg <= 1'b0;
            pwm_reg <= 8'h00;
            reduce_reg <= 8'hff;
            REG_RDATA <= 32'h0000_0000;
            BRIDGE_EN <= 1'b0;
            COASTING <= 1'b0;
            ACTIVE_CURRENT <= CURRENT_RESET;
        end else begin
            setpoint_reg <= setpoint_next;
            state_reg <= state_next;
            cur_reg <= cur_next;
            tmr_reg <= tmr_next;
            units_reg <= units_next;
            step_q_reg <= STEP;
            pwm_reg <= pwm_next;
            reduce_reg <= reduce_next;
            REG_RDATA <= rdata_next;
            BRIDGE_EN <= en_next;
            COASTING <= coast_next;
            ACTIVE_CURRENT <= cur_next;
        end
    end
endmodule // dc_motor_direct_drive

// ---- tb/dc_drive_chk.sv ----
// Purpose: Port assertions for the direct-drive block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the block
`timescale 1ns/10ps
module dc_drive_chk
    import dc_drive_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic DIRECT_MODE,
    input wire logic VOLT_MODE,
    input wire logic [3:0] CHOPPER_OFF_TIME,
    input wire logic STEP,
    input wire logic [4:0] MOVING_CURRENT,
    input wire logic [8:0] SENSE_A,
    input wire logic COIL_A_POS,
    input wire logic COIL_A_NEG,
    input wire logic COIL_B_POS,
    input wire logic COIL_B_NEG,
    input wire logic BRIDGE_EN,
    input wire logic COASTING,
    input wire logic [4:0] ACTIVE_CURRENT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    off_time_gate_a: assert property ((CHOPPER_OFF_TIME == 4'h0) [*2]
        |-> !BRIDGE_EN) else $error("bridge on with zero off-time");
    coast_gate_a: assert property (COASTING |-> !BRIDGE_EN)
        else $error("bridge on while coasting");
    no_shoot_a: assert property (!(COIL_A_POS && COIL_A_NEG)
        && !(COIL_B_POS && COIL_B_NEG)) else $error("both bridge sides on");
    quiet_bridge_a: assert property ((!BRIDGE_EN) [*3] |-> !COIL_A_POS
        && !COIL_A_NEG && !COIL_B_POS && !COIL_B_NEG)
        else $error("coil driven while bridge off");
    step_boost_a: assert property ($rose(STEP) && DIRECT_MODE
        |-> ##[1:2] ACTIVE_CURRENT == MOVING_CURRENT)
        else $error("step did not raise current");
    unmapped_read_a: assert property (REG_ADDR != COIL_PWM_SETPOINT_ADDR
        |=> REG_RDATA == 32'h0) else $error("unmapped read not zero");
    readback_a: assert property (
        (REG_WR && REG_ADDR == COIL_PWM_SETPOINT_ADDR)
        ##1 (REG_ADDR == COIL_PWM_SETPOINT_ADDR && !REG_WR) [*3]
        |=> REG_RDATA == $past(REG_WDATA, 4)) else $error("readback wrong");
    hyst_limit_a: assert property (
        (!VOLT_MODE && SENSE_A == 9'h1ff) [*4]
        |-> !COIL_A_POS && !COIL_A_NEG) else $error("coil on above limit");
endmodule // dc_drive_chk
bind dc_motor_direct_drive dc_drive_chk u_dc_drive_chk (.*);

// ---- tb/coil_model.sv ----
// Purpose: Coil current model behind one bridge
// Assumes: Current rises while driven and decays when off
// Notes: Overload pins the sensed value at full scale
`timescale 1ns/10ps
module coil_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bridge drive and forced fault
    input wire logic pos,
    input wire logic neg,
    input wire logic overload,
    // Sensed current
    output logic [8:0] sense
);
    always_ff @(posedge clk) begin
        if (!rst_n) sense <= 9'h000;
        else if (overload) sense <= 9'h1ff;
        else if (pos || neg)
            sense <= (sense > 9'h1fb) ? 9'h1ff : sense + 9'h004;
        else if (sense != 9'h000) sense <= sense - 9'h001;
    end
endmodule // coil_model

// ---- tb/dc_motor_direct_drive_tb.sv ----
// Purpose: Self-checking bench for the direct-drive block
// Assumes: 20 MHz clock, inputs driven 5 ns after the edge
// Notes: Two coil models supply sensed current
`timescale 1ns/10ps
module dc_motor_direct_drive_tb;
    import dc_drive_pkg::*;
    logic CLK = 1'b0, RESETN = 1'b0, REG_WR = 1'b0, STEP = 1'b0;
    logic DIRECT_MODE = 1'b0, VOLT_MODE = 1'b1, AUTOSCALE = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, IDLE_REDUCE_DELAY = 8'h01;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
    logic [3:0] CHOPPER_OFF_TIME = 4'h3, CURRENT_DECAY_STEPS = 4'h1;
    logic [4:0] STANDSTILL_CURRENT = 5'h1f, MOVING_CURRENT = 5'h14;
    logic [4:0] ACTIVE_CURRENT;
    logic [1:0] COAST_SELECT = 2'h0;
    logic [8:0] MOTION_COIL_A = 9'h0, MOTION_COIL_B = 9'h0, SENSE_A, SENSE_B;
    logic COIL_A_POS, COIL_A_NEG, COIL_B_POS, COIL_B_NEG, BRIDGE_EN, COASTING;
    logic load_a = 1'b0, load_b = 1'b0;
    int fails = 0, num_checks = 0, cycles = 0, n_ap, n_an, n_bp, n_bn;
    logic [8:0] max_a, max_b;
    localparam logic [7:0] SP = COIL_PWM_SETPOINT_ADDR;
    dc_motor_direct_drive u_dc_motor_direct_drive (.*);
    coil_model u_coil_model_a (.clk(CLK), .rst_n(RESETN), .pos(COIL_A_POS),
        .neg(COIL_A_NEG), .overload(load_a), .sense(SENSE_A));
    coil_model u_coil_model_b (.clk(CLK), .rst_n(RESETN), .pos(COIL_B_POS),
        .neg(COIL_B_NEG), .overload(load_b), .sense(SENSE_B));
    // Scenarios need about 16000 cycles
    localparam int MAX_CYCLES = 30000;
    initial forever #25 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles++;
        if (cycles == MAX_CYCLES) begin
            fails++;
            report_and_stop();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge CLK);
        #5;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task ok(input logic c);
        chk({31'h0, c}, 32'h1);
    endtask
    // One-cycle strobe, then an idle edge so writes never merge
    task wr(input logic [7:0] a, input logic [31:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        tick(1);
        REG_WR = 1'b0;
        tick(1);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        REG_ADDR = a;
        tick(4);
        d = REG_RDATA;
    endtask
    task measure(input int n);
        n_ap = 0;
        n_an = 0;
        n_bp = 0;
        n_bn = 0;
        max_a = 9'h000;
        max_b = 9'h000;
        repeat (n) begin
            tick(1);
            n_ap += int'(COIL_A_POS === 1'b1);
            n_an += int'(COIL_A_NEG === 1'b1);
            n_bp += int'(COIL_B_POS === 1'b1);
            n_bn += int'(COIL_B_NEG === 1'b1);
            if (SENSE_A > max_a) max_a = SENSE_A;
            if (SENSE_B > max_b) max_b = SENSE_B;
        end
    endtask
    task t_regs;
        logic [31:0] d;
        rd(SP, d);
        chk(d, COIL_PWM_SETPOINT_RESET);
        wr(SP, 32'ha5a5_5a5a);
        rd(SP, d);
        chk(d, 32'ha5a5_5a5a);
        wr(8'h2c, 32'h1234_5678);
        rd(SP, d);
        chk(d, 32'ha5a5_5a5a);
        rd(8'h2c, d);
        chk(d, 32'h0);
    endtask
    task t_hyst;
        DIRECT_MODE = 1'b1;
        VOLT_MODE = 1'b0;
        wr(SP, 32'h0000_0064);
        tick(200);
        measure(510);
        ok(n_ap > 0 && n_ap < 500 && n_an == 0);
        ok(max_a >= 90 && max_a <= 115);
        STANDSTILL_CURRENT = 5'h08;
        tick(200);
        measure(510);
        ok(max_a >= 15 && max_a <= 40);
        load_a = 1'b1;
        wr(SP, 32'h019c_0064);
        tick(200);
        measure(510);
        ok(n_ap == 0 && n_bn > 0 && n_bp == 0);
        load_a = 1'b0;
    endtask
    task t_volt;
        VOLT_MODE = 1'b1;
        STANDSTILL_CURRENT = 5'h1f;
        load_a = 1'b1;
        load_b = 1'b1;
        wr(SP, 32'hff01_fe80);
        tick(3);
        measure(510);
        ok(n_ap >= 240 && n_ap <= 270 && n_an == 0);
        ok(n_bn >= 490 && n_bp == 0);
        AUTOSCALE = 1'b1;
        tick(10200);
        measure(510);
        ok(n_ap < 240 && n_bn < 490);
        AUTOSCALE = 1'b0;
        load_a = 1'b0;
        load_b = 1'b0;
    endtask
    task t_bridge;
        CHOPPER_OFF_TIME = 4'h0;
        tick(3);
        measure(300);
        ok(BRIDGE_EN === 1'b0 && n_ap + n_bn == 0);
        CHOPPER_OFF_TIME = 4'h3;
        tick(3);
        ok(BRIDGE_EN === 1'b1);
        STANDSTILL_CURRENT = 5'h00;
        COAST_SELECT = 2'h1;
        tick(3);
        ok(COASTING === 1'b1 && BRIDGE_EN === 1'b0);
        COAST_SELECT = 2'h2;
        tick(3);
        ok(COASTING === 1'b0);
        STANDSTILL_CURRENT = 5'h08;
        COAST_SELECT = 2'h0;
    endtask
    // Sense may start near full scale, so settle long enough to decay
    task t_step;
        VOLT_MODE = 1'b0;
        wr(SP, 32'h019c_0064);
        tick(500);
        measure(300);
        ok(max_a <= 40 && max_b <= 40);
        MOVING_CURRENT = 5'h1f;
        STEP = 1'b1;
        tick(3);
        STEP = 1'b0;
        chk({27'h0, ACTIVE_CURRENT}, 32'h1f);
        tick(200);
        measure(300);
        ok(max_a >= 90 && max_b >= 90);
    endtask
    task t_motion;
        VOLT_MODE = 1'b1;
        DIRECT_MODE = 1'b0;
        MOTION_COIL_A = 9'h0ff;
        wr(SP, 32'h0);
        tick(3);
        measure(510);
        ok(n_ap >= 490);
        DIRECT_MODE = 1'b1;
        MOTION_COIL_B = 9'h101;
        tick(3);
        repeat (4) begin
            STEP = 1'b1;
            tick(2);
            STEP = 1'b0;
            tick(2);
        end
        measure(510);
        ok(n_ap + n_an + n_bp + n_bn == 0);
    endtask
    task report_and_stop;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        tick(16);
        RESETN = 1'b1;
        t_regs;
        t_hyst;
        t_volt;
        t_bridge;
        t_step;
        t_motion;
        report_and_stop();
    end
endmodule // dc_motor_direct_drive_tb
